// *** logic/csr_consts.vh ***
// constants for the charge status reporter: timing, pulse codes, charger state codes
// assumes a 50 MHz system clock and an externally pulled-up report line
// Function
// - status outputs are open-drain, pull low when lit
// - disabled or low supply: both indicators released
// - no battery and no fault: both outputs flash together, capacitor-paced
// - charging a only, done b only, fault both
// - report line active low, shared, pulled up
// - after strobe rise, wait delay, send pulses
// - codes 1..3 faults, 4 unused, 23 error
// - 5 precondition timeout, 6 preconditioning
// - 7 cc timeout, 8 cc thermal, 9 cc
// - 10 cv timeout, 11 cv, 12 done
// - over-voltage: fault leds, code on line
// - battery over-temperature: report code 2, fault leds
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH

// clock period in ns
`define CSR_CLK_NS 20
// least host strobe, ns, and cycles (rounded up)
`define CSR_REQ_LOW_NS 200
`define CSR_REQ_LOW_CYC ((`CSR_REQ_LOW_NS + `CSR_CLK_NS - 1) / `CSR_CLK_NS)
// longest accepted strobe, ns (plain default, adjust to the host's pull-up)
`define CSR_REQ_MAX_NS 100000
`define CSR_REQ_MAX_CYC (`CSR_REQ_MAX_NS / `CSR_CLK_NS)
// report delay, ns, and cycles
`define CSR_RPT_DLY_NS 2000
`define CSR_RPT_DLY_CYC (`CSR_RPT_DLY_NS / `CSR_CLK_NS)
// low half and full period of a report pulse, ns and cycles
`define CSR_PULSE_LO_NS 1000
`define CSR_PULSE_LO_CYC (`CSR_PULSE_LO_NS / `CSR_CLK_NS)
`define CSR_PULSE_PER_NS 2000
`define CSR_PULSE_PER_CYC (`CSR_PULSE_PER_NS / `CSR_CLK_NS)

// pulse counts
`define CSR_N_DIE_HOT 5'h01
`define CSR_N_BAT_TEMP 5'h02
`define CSR_N_OVERVOLT 5'h03
`define CSR_N_PRE_WDOG 5'h05
`define CSR_N_PRE 5'h06
`define CSR_N_CC_WDOG 5'h07
`define CSR_N_CC_THERM 5'h08
`define CSR_N_CC 5'h09
`define CSR_N_CV_WDOG 5'h0a
`define CSR_N_CV 5'h0b
`define CSR_N_DONE 5'h0c
`define CSR_N_ERROR 5'h17

// charger state codes on i_chg_state
`define CSR_ST_PRE 3'h0
`define CSR_ST_CC 3'h1
`define CSR_ST_CV 3'h2
`define CSR_ST_DONE 3'h3

`endif

// *** logic/csr_sync2.v ***
// two-flop synchroniser for one level from outside the clock domain
// assumes the input is a plain level; first flop feeds only the second
`timescale 1ns/100ps
module csr_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input wire i_clk, // system clock
  input wire i_sys_rst, // synchronous reset, active high
  input wire i_async, // asynchronous level
  output reg o_sync // synchronised level
);
  reg meta; // first stage, read only by o_sync

  // two stages in series
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // csr_sync2

// *** logic/csr_top.v ***
// charge status reporter: two open-drain led drivers and the single-wire report
// assumes charger condition inputs are asynchronous levels from analog blocks
`timescale 1ns/100ps
`include "csr_consts.vh"
module csr_top #(
  parameter REQ_MAX_CYC = `CSR_REQ_MAX_CYC, // longest accepted strobe, cycles
  parameter RPT_DLY_CYC = `CSR_RPT_DLY_CYC, // report delay, cycles
  parameter PULSE_LO_CYC = `CSR_PULSE_LO_CYC, // low time of a pulse
  parameter PULSE_PER_CYC = `CSR_PULSE_PER_CYC // full pulse period
) (
  input wire i_clk, // system clock 50 MHz
  input wire i_sys_rst, // synchronous reset, active high
  input wire i_chg_en, // charging enabled
  input wire i_adapter_ok, // adapter_voltage above lockout
  input wire i_bat_present, // battery attached
  input wire i_flash, // capacitor-paced flash oscillator level
  input wire i_die_hot, // die over-temperature shutdown
  input wire i_bat_temp_fault, // battery temperature out of window
  input wire i_overvolt, // battery over-voltage
  input wire i_wdog_timeout, // watchdog expired in present mode
  input wire i_thermal_loop, // thermal loop reducing cc current
  input wire [2:0] i_chg_state, // charge mode code
  input wire i_report_in, // report line level
  output reg o_report_out, // report line drive value (always 0)
  output reg o_report_oe_n, // report line enable, low drives
  output reg o_status_led_a_oe_n, // led a enable, low pulls cathode
  output reg o_status_led_b_oe_n, // led b enable, low pulls cathode
  output reg o_status_led_a_out, // led a drive value (always 0)
  output reg o_status_led_b_out // led b drive value (always 0)
);
  localparam S_IDLE = 2'h0; // waiting for strobe
  localparam S_REQ = 2'h1; // strobe low, timing it
  localparam S_DLY = 2'h2; // report delay
  localparam S_SEND = 2'h3; // sending pulses

  wire [10:0] sv; // synchronised condition levels
  wire line_s; // synchronised report line
  reg line_d; // previous line level for edge detect
  reg [1:0] state; // report state
  reg [1:0] next_state;
  reg [15:0] cnt; // cycle counter
  reg [15:0] next_cnt;
  reg [4:0] left; // pulses still to send
  reg [4:0] next_left;
  reg overlong; // strobe ran past the maximum
  reg next_overlong;
  reg [4:0] code; // pulse count for the present state
  reg next_a; // led a lit
  reg next_b; // led b lit
  reg next_drive; // pull report line low

  // raw condition levels, one bit per synchroniser; bit 2 of the mode code
  // is left out on purpose, so modes 4 to 7 alias 0 to 3
  wire [10:0] raw = {i_chg_en, i_adapter_ok, i_bat_present, i_flash, i_die_hot,
    i_bat_temp_fault, i_overvolt, i_wdog_timeout, i_thermal_loop, i_chg_state[1:0]};

  // levels from the analog side cross into the clock domain
  genvar g;
  generate
    for (g = 0; g < 11; g = g + 1)
    begin : g_sync
      csr_sync2 #(.RST_VAL(1'b0)) u_s (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(raw[g]),
        .o_sync(sv[g])
      );
    end
  endgenerate
  wire en_s = sv[10];
  wire adp_s = sv[9];
  wire bat_s = sv[8];
  wire flash_s = sv[7];
  wire hot_s = sv[6];
  wire btemp_s = sv[5];
  wire ov_s = sv[4];
  wire wdog_s = sv[3];
  wire therm_s = sv[2];
  wire [1:0] mode_s = sv[1:0];
  wire fault_s = hot_s | btemp_s | ov_s | wdog_s;

  // the line idles high by pull-up, so reset to high
  csr_sync2 #(.RST_VAL(1'b1)) u_line (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_report_in),
    .o_sync(line_s)
  );

  // pulse count from the charger condition, die, battery-temperature and over-voltage faults first
  always @*
  begin
    if (hot_s)
      code = `CSR_N_DIE_HOT;
    else if (btemp_s)
      code = `CSR_N_BAT_TEMP;
    else if (ov_s)
      code = `CSR_N_OVERVOLT;
    else
    begin
      case ({1'b0, mode_s})
        `CSR_ST_PRE: code = wdog_s ? `CSR_N_PRE_WDOG : `CSR_N_PRE;
        `CSR_ST_CC: code = wdog_s ? `CSR_N_CC_WDOG :
          (therm_s ? `CSR_N_CC_THERM : `CSR_N_CC);
        `CSR_ST_CV: code = wdog_s ? `CSR_N_CV_WDOG : `CSR_N_CV;
        `CSR_ST_DONE: code = `CSR_N_DONE;
        default: code = `CSR_N_ERROR;
      endcase
    end
  end

  // led pattern; the flash pace comes from the external capacitor
  always @*
  begin
    if (!en_s || !adp_s)
    begin
      next_a = 1'b0;
      next_b = 1'b0;
    end
    else if (fault_s)
    begin
      next_a = 1'b1;
      next_b = 1'b1;
    end
    else if (!bat_s)
    begin
      next_a = flash_s;
      next_b = flash_s;
    end
    else if ({1'b0, mode_s} == `CSR_ST_DONE)
    begin
      next_a = 1'b0;
      next_b = 1'b1;
    end
    else
    begin
      next_a = 1'b1;
      next_b = 1'b0;
    end
  end

  // report sequencer: time strobe, wait, then emit pulses
  always @*
  begin
    next_state = state;
    next_cnt = cnt;
    next_left = left;
    next_overlong = overlong;
    next_drive = 1'b0;
    case (state)
      S_IDLE:
      begin
        next_cnt = 16'h0000;
        next_overlong = 1'b0;
        if (line_d && !line_s)
          next_state = S_REQ;
      end
      S_REQ:
      begin
        if (cnt != 16'hffff)
          next_cnt = cnt + 16'h0001;
        if (cnt >= REQ_MAX_CYC[15:0])
          next_overlong = 1'b1;
        if (line_s)
        begin
          // short glitches are too brief to be a request
          if (cnt + 16'h0001 >= `CSR_REQ_LOW_CYC)
          begin
            next_state = S_DLY;
            next_left = overlong ? `CSR_N_ERROR : code;
          end
          else
            next_state = S_IDLE;
          next_cnt = 16'h0000;
        end
      end
      S_DLY:
      begin
        next_cnt = cnt + 16'h0001;
        if (cnt + 16'h0001 >= RPT_DLY_CYC[15:0])
        begin
          next_state = S_SEND;
          next_cnt = 16'h0000;
        end
      end
      S_SEND:
      begin
        next_drive = (cnt < PULSE_LO_CYC[15:0]);
        next_cnt = cnt + 16'h0001;
        if (cnt + 16'h0001 >= PULSE_PER_CYC[15:0])
        begin
          next_cnt = 16'h0000;
          next_left = left - 5'h01;
          if (left == 5'h01)
            next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // registers and open-drain outputs; enable low means pull low
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state <= S_IDLE;
      cnt <= 16'h0000;
      left <= 5'h00;
      overlong <= 1'b0;
      line_d <= 1'b1;
      o_report_out <= 1'b0;
      o_report_oe_n <= 1'b1;
      o_status_led_a_oe_n <= 1'b1;
      o_status_led_b_oe_n <= 1'b1;
      o_status_led_a_out <= 1'b0;
      o_status_led_b_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      left <= next_left;
      overlong <= next_overlong;
      line_d <= line_s;
      o_report_out <= 1'b0;
      o_report_oe_n <= !next_drive;
      o_status_led_a_oe_n <= !next_a;
      o_status_led_b_oe_n <= !next_b;
      o_status_led_a_out <= 1'b0;
      o_status_led_b_out <= 1'b0;
    end
  end
endmodule // csr_top

// *** tb/csr_chk.sv ***
// port checker for the charge status reporter
// assumes the bench runs short pulse timing; bound into csr_top below
`timescale 1ns/100ps
module csr_chk #(
  parameter PULSE_LO_CYC = 2 // low time of a pulse
) (
  input wire i_clk, // clock
  input wire i_sys_rst, // reset
  input wire i_chg_en, // enable
  input wire i_adapter_ok, // supply good
  input wire i_bat_present, // battery
  input wire i_die_hot, // fault
  input wire i_bat_temp_fault, // fault
  input wire i_overvolt, // fault
  input wire i_wdog_timeout, // fault
  input wire [2:0] i_chg_state, // mode
  input wire i_report_in, // line level
  input wire o_report_out, // line value
  input wire o_report_oe_n, // line enable
  input wire o_status_led_a_oe_n, // led a
  input wire o_status_led_b_oe_n, // led b
  input wire o_status_led_a_out, // led a value
  input wire o_status_led_b_out // led b value
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire run = i_chg_en && i_adapter_ok; // charger live
  wire flt = i_die_hot || i_bat_temp_fault || i_overvolt || i_wdog_timeout; // any fault
  wire dn = i_chg_state[1:0] == 2'h3; // charge ended
  reg [15:0] low_n; // cycles the line has been driven low
  // four-cycle holds below cover the three-edge sync latency
  always @(posedge i_clk)
  begin
    low_n <= (i_sys_rst || o_report_oe_n) ? 16'h0000 : low_n + 16'h0001;
  end
  drive_zero_a: assert property (!o_report_out && !o_status_led_a_out
    && !o_status_led_b_out)
    else $error("drive value not zero");
  leds_off_a: assert property ((!run)[*4]
    |-> o_status_led_a_oe_n && o_status_led_b_oe_n)
    else $error("leds lit while idle");
  fault_on_a: assert property ((run && flt)[*4]
    |-> !o_status_led_a_oe_n && !o_status_led_b_oe_n)
    else $error("fault pattern missing");
  flash_same_a: assert property ((run && !flt && !i_bat_present)[*4]
    |-> o_status_led_a_oe_n == o_status_led_b_oe_n)
    else $error("flash leds differ");
  charging_a: assert property ((run && !flt && i_bat_present && !dn)[*4]
    |-> !o_status_led_a_oe_n && o_status_led_b_oe_n)
    else $error("charging pattern wrong");
  done_leds_a: assert property ((run && !flt && i_bat_present && dn)[*4]
    |-> o_status_led_a_oe_n && !o_status_led_b_oe_n)
    else $error("done pattern wrong");
  reply_wait_a: assert property ($rose(i_report_in) && $past(o_report_oe_n)
    |-> o_report_oe_n[*5])
    else $error("reply too early");
  pulse_width_a: assert property ($rose(o_report_oe_n) |-> low_n == PULSE_LO_CYC)
    else $error("pulse width wrong");
endmodule // csr_chk

bind csr_top csr_chk #(.PULSE_LO_CYC(PULSE_LO_CYC)) u_chk (.i_clk, .i_sys_rst, .i_chg_en,
  .i_adapter_ok, .i_bat_present, .i_die_hot, .i_bat_temp_fault, .i_overvolt, .i_wdog_timeout,
  .i_chg_state, .i_report_in, .o_report_out, .o_report_oe_n, .o_status_led_a_oe_n,
  .o_status_led_b_oe_n, .o_status_led_a_out, .o_status_led_b_out);

// *** tb/csr_host.sv ***
// host model: strobes the report line and counts the reply pulses
// assumes a pulled-up line resolved by the bench
`timescale 1ns/100ps
module csr_host (
  input wire i_clk, // clock
  input wire i_line, // resolved line level
  input wire i_go, // start a request
  input wire [7:0] i_len, // strobe length, cycles
  output reg o_pull, // high pulls the line low
  output reg [4:0] o_count, // falling edges seen
  output reg o_done // reply finished, one cycle
);
  reg [7:0] left = 8'h00; // strobe cycles remaining
  reg [4:0] idle = 5'h00; // high cycles in a row
  reg busy = 1'b0; // request in flight
  reg prev = 1'b1; // last line level
  initial o_pull = 1'b0;
  initial o_count = 5'h00;
  initial o_done = 1'b0;
  // strobe, then count until the line rests high well past a pulse period
  always @(posedge i_clk)
  begin
    prev <= i_line;
    o_done <= 1'b0;
    if (i_go && !busy)
    begin
      busy <= 1'b1;
      o_pull <= 1'b1;
      left <= i_len;
      o_count <= 5'h00;
      idle <= 5'h00;
    end
    else if (o_pull)
    begin
      o_pull <= left > 8'h01;
      left <= left - 8'h01;
    end
    else if (busy)
    begin
      if (prev && !i_line)
        o_count <= o_count + 5'h01;
      idle <= i_line ? idle + 5'h01 : 5'h00;
      if (idle == 5'h13)
      begin
        busy <= 1'b0;
        o_done <= 1'b1;
      end
    end
  end
endmodule // csr_host

// *** tb/test_csr_top.sv ***
// self-checking bench for csr_top with short report timing
// assumes csr_host as the polling host
`timescale 1ns/100ps
module test_csr_top;
  reg i_clk = 1'b0;
  reg i_sys_rst = 1'b1;
  reg [11:0] cond = 12'h000; // en ok present flash die btemp ov wdog therm state
  reg go = 1'b0;
  reg [7:0] len = 8'h00;
  wire [4:0] cnt;
  wire done, pull, r_out, r_oe_n, a_oe_n, b_oe_n;
  wire line = ((!r_oe_n && !r_out) || pull) ? 1'b0 : 1'b1; // pull-up wins when released
  integer miscompares = 0, checked = 0, cycles = 0, i;
  reg [4:0] got, s0;
  localparam [11*17-1:0] CODES = {12'he81, 5'h01, 12'he41, 5'h02, 12'he21, 5'h03,
    12'he10, 5'h05, 12'he00, 5'h06, 12'he11, 5'h07, 12'he09, 5'h08, 12'he01, 5'h09,
    12'he12, 5'h0a, 12'he02, 5'h0b, 12'he03, 5'h0c};
  localparam [8*14-1:0] LEDS = {12'h600, 2'h3, 12'ha00, 2'h3, 12'he01, 2'h1, 12'he03, 2'h2,
    12'he81, 2'h0, 12'he11, 2'h0, 12'he41, 2'h0, 12'he21, 2'h0};
  initial
  begin
    forever #10 i_clk = ~i_clk;
  end
  csr_top #(.REQ_MAX_CYC(50), .RPT_DLY_CYC(5), .PULSE_LO_CYC(2), .PULSE_PER_CYC(4)) u_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_chg_en(cond[11]), .i_adapter_ok(cond[10]),
    .i_bat_present(cond[9]), .i_flash(cond[8]), .i_die_hot(cond[7]),
    .i_bat_temp_fault(cond[6]), .i_overvolt(cond[5]), .i_wdog_timeout(cond[4]),
    .i_thermal_loop(cond[3]), .i_chg_state(cond[2:0]), .i_report_in(line),
    .o_report_out(r_out), .o_report_oe_n(r_oe_n), .o_status_led_a_oe_n(a_oe_n),
    .o_status_led_b_oe_n(b_oe_n), .o_status_led_a_out(), .o_status_led_b_out());
  csr_host u_host (.i_clk(i_clk), .i_line(line), .i_go(go), .i_len(len), .o_pull(pull),
    .o_count(cnt), .o_done(done));
  task check(input string what, input [4:0] seen, input [4:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // conditions need three edges to reach the leds; six leaves margin
  task set_cond(input [11:0] v);
    @(posedge i_clk);
    cond <= v;
    repeat (6) @(posedge i_clk);
  endtask
  task ask(input [7:0] n);
    @(posedge i_clk);
    go <= 1'b1;
    len <= n;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (400)
    begin
      @(posedge i_clk);
      if (done === 1'b1)
        break;
    end
    check("reply end", {4'h0, done}, 5'h01);
    got = cnt;
  endtask
  // reset in mid-run releases both leds, then the fault pattern returns
  task t_reset;
    set_cond(12'he21);
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    check("reset release", {3'h0, a_oe_n, b_oe_n}, 5'h03);
    i_sys_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    check("fault after reset", {3'h0, a_oe_n, b_oe_n}, 5'h00);
  endtask
  task t_leds;
    for (i = 0; i < 8; i = i + 1)
    begin
      set_cond(LEDS[i*14+2 +: 12]);
      check("led pattern", {3'h0, a_oe_n, b_oe_n}, {3'h0, LEDS[i*14 +: 2]});
    end
    set_cond(12'hc00);
    s0 = {3'h0, a_oe_n, b_oe_n};
    set_cond(12'hd00);
    check("flash pair", {4'h0, a_oe_n ^ b_oe_n}, 5'h00);
    check("flash toggle", {4'h0, s0 !== {3'h0, a_oe_n, b_oe_n}}, 5'h01);
  endtask
  task t_codes;
    for (i = 0; i < 11; i = i + 1)
    begin
      set_cond(CODES[i*17+5 +: 12]);
      ask(8'h14);
      check("pulse count", got, CODES[i*17 +: 5]);
    end
  endtask
  // shortest legal strobe, one too short, one overlong
  task t_strobes;
    set_cond(12'he01);
    ask(8'h0a);
    check("edge strobe", got, 5'h09);
    ask(8'h05);
    check("short strobe", got, 5'h00);
    ask(8'h3c);
    check("long strobe", got, 5'h17);
  endtask
  // a hang ends the run as a mismatch
  always @(posedge i_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  initial
  begin
    repeat (8) @(posedge i_clk);
    check("reset leds", {3'h0, a_oe_n, b_oe_n}, 5'h03);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    t_leds;
    t_reset;
    t_codes;
    t_strobes;
    end_sim;
  end
endmodule // test_csr_top
